// ### rtl/jinc_defines.svh
`ifndef JINC_DEFINES_SVH
`define JINC_DEFINES_SVH

// Instruction word layout
`define JINC_OP_JUMP       3'h5
`define JINC_OP_JUMP_MSB   13
`define JINC_OP_JUMP_LSB   11
`define JINC_OP_INC        6'h0A
`define JINC_OP_INC_MSB    13
`define JINC_OP_INC_LSB    8
`define JINC_IMM_MSB       10
`define JINC_DEST_BIT      7
`define JINC_FADDR_MSB     6

// Program counter high latch field that feeds the top of the counter
`define JINC_LATCH_HI      4
`define JINC_LATCH_LO      3

// Reset values
`define JINC_PC_RESET      13'h0000
`define JINC_ACC_RESET     8'h00

`endif

// ### rtl/jinc_pkg.sv
`default_nettype none

package jinc_pkg;

    // One state per internal phase of an instruction cycle
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } jinc_phase_t;

    typedef struct packed {
        jinc_phase_t phase;
        logic        secondCyc;
        logic [13:0] instr;
        logic [12:0] pc;
        logic [7:0]  accum;
        logic        zero;
        logic [7:0]  result;
        logic        busy;
        logic        done;
    } jinc_state_t;

endpackage

`default_nettype wire

// ### rtl/jinc_file_ram.sv
`timescale 1ns/1ps
`default_nettype none

module jinc_file_ram (
    input  wire logic       sys_clk,
    input  wire logic       we,
    input  wire logic [6:0] wAddr,
    input  wire logic [7:0] wData,
    input  wire logic [6:0] rAddr,
    output var  logic [7:0] rdData_r
);

    logic [7:0] mem [0:127];

    // Registered read: data appears one clock after the address
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[wAddr] <= wData;
        end
        rdData_r <= mem[rAddr];
    end

endmodule

`default_nettype wire

// ### rtl/jinc_execute.sv
// Function
// - Jump loads its 11-bit immediate into program counter bits 10..0.
// - Jump loads program counter bits 12..11 from latch bits 4..3.
// - Jump takes two instruction cycles and leaves status flags alone.
// - Increment adds one to the file register, 0xFF wrapping to 0x00.
// - Destination bit 0 sends result to accumulator, 1 back to register.
// - Increment completes in one cycle: decode, read, compute, write phases.
`timescale 1ns/1ps
`default_nettype none
`include "jinc_defines.svh"

module jinc_execute (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        instrStart,
    input  wire logic [13:0] instrWord,
    input  wire logic [4:0]  pcHighLatch,
    input  wire logic        extWe,
    input  wire logic [6:0]  extAddr,
    input  wire logic [7:0]  extData,
    output var  logic [12:0] pc_r,
    output var  logic [7:0]  accum_r,
    output var  logic        zeroFlag_r,
    output var  logic        busy_r,
    output var  logic        done_r,
    output var  logic [7:0]  dbgRdData_r
);

    jinc_pkg::jinc_state_t s_r;
    jinc_pkg::jinc_state_t s_nxt;
    logic                  memWe;
    logic [6:0]            memWAddr;
    logic [7:0]            memWData;
    logic [6:0]            memRAddr;
    logic [7:0]            memRdData;
    logic                  isJump;
    logic                  isInc;
    logic [6:0]            fAddr;

    // Decode of the latched instruction word
    assign isJump = s_r.instr[`JINC_OP_JUMP_MSB:`JINC_OP_JUMP_LSB] == `JINC_OP_JUMP;
    assign isInc  = s_r.instr[`JINC_OP_INC_MSB:`JINC_OP_INC_LSB] == `JINC_OP_INC;
    assign fAddr  = s_r.instr[`JINC_FADDR_MSB:0];

    // File register bank; external writes only reach it while idle, and extAddr drives its read address in every phase but Q2
    jinc_file_ram u_ram (
        .sys_clk  (sys_clk),
        .we       (memWe),
        .wAddr    (memWAddr),
        .wData    (memWData),
        .rAddr    (memRAddr),
        .rdData_r (memRdData)
    );

    // Phase sequencer and datapath
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        memWe      = 1'b0;
        memWAddr   = extAddr;
        memWData   = extData;
        memRAddr   = extAddr;
        case (s_r.phase)
            jinc_pkg::PH_IDLE: begin
                // Bank port is open only between instructions, so it never races write-back
                memWe = extWe;
                if (instrStart) begin
                    s_nxt.instr     = instrWord;
                    s_nxt.secondCyc = 1'b0;
                    s_nxt.busy      = 1'b1;
                    s_nxt.phase     = jinc_pkg::PH_Q1;
                end
            end
            jinc_pkg::PH_Q1: begin
                s_nxt.phase = jinc_pkg::PH_Q2; // Decode phase, word already latched
            end
            jinc_pkg::PH_Q2: begin
                memRAddr    = fAddr;
                s_nxt.phase = jinc_pkg::PH_Q3;
            end
            jinc_pkg::PH_Q3: begin
                // Read data was registered at the end of Q2, so it is settled here
                if (isInc && !s_r.secondCyc) begin
                    s_nxt.result = 8'(memRdData + 8'h01);
                end
                s_nxt.phase = jinc_pkg::PH_Q4;
            end
            jinc_pkg::PH_Q4: begin
                // Latch bits are taken in Q4 of the first cycle, so updates up to then still count
                if (!s_r.secondCyc && isJump) begin
                    s_nxt.pc[`JINC_IMM_MSB:0] = s_r.instr[`JINC_IMM_MSB:0];
                    s_nxt.pc[12:11] = pcHighLatch[`JINC_LATCH_HI:`JINC_LATCH_LO];
                end
                if (!s_r.secondCyc && isInc) begin
                    if (s_r.instr[`JINC_DEST_BIT]) begin
                        memWe    = 1'b1;
                        memWAddr = fAddr;
                        memWData = s_r.result;
                    end else begin
                        s_nxt.accum = s_r.result;
                    end
                    s_nxt.zero = (s_r.result == 8'h00);
                end
                // Jump spends a second, empty cycle while fetch refills
                if (!s_r.secondCyc && isJump) begin
                    s_nxt.secondCyc = 1'b1;
                    s_nxt.phase     = jinc_pkg::PH_Q1;
                end else begin
                    s_nxt.phase = jinc_pkg::PH_IDLE;
                    s_nxt.busy  = 1'b0;
                    s_nxt.done  = 1'b1;
                end
            end
            default: begin
                s_nxt.phase = jinc_pkg::PH_IDLE;
                s_nxt.busy  = 1'b0;
            end
        endcase
        if (rst) begin
            memWe = 1'b0; // No stray writes while held in reset
        end
    end

    // State register; the all-zero value is the idle state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_r       <= '0;
            s_r.pc    <= `JINC_PC_RESET;
            s_r.accum <= `JINC_ACC_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs other than dbgRdData_r come straight from the state register; dbgRdData_r comes from the bank read register
    assign pc_r        = s_r.pc;
    assign accum_r     = s_r.accum;
    assign zeroFlag_r  = s_r.zero;
    assign busy_r      = s_r.busy;
    assign done_r      = s_r.done;
    assign dbgRdData_r = memRdData;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Checks on the execution sequence
    jump_low_a: assert property ((s_r.phase == jinc_pkg::PH_Q4) && !s_r.secondCyc && isJump
        |=> pc_r[10:0] == $past(s_r.instr[10:0])) else $error("jump low bits wrong");
    jump_high_a: assert property ((s_r.phase == jinc_pkg::PH_Q4) && !s_r.secondCyc && isJump
        |=> pc_r[12:11] == $past(pcHighLatch[4:3])) else $error("jump high bits wrong");
    jump_length_a: assert property (!busy_r && instrStart && instrWord[13:11] == 3'h5
        |=> !done_r [*8] ##1 done_r) else $error("jump not two cycles");
    jump_flags_a: assert property (!busy_r && instrStart && instrWord[13:11] == 3'h5
        |=> $stable(zeroFlag_r) [*8]) else $error("jump changed zero flag");
    inc_wrap_a: assert property ((s_r.phase == jinc_pkg::PH_Q3) && isInc && !s_r.secondCyc
        |=> s_r.result == 8'($past(memRdData) + 8'h01)) else $error("increment wrong");
    dest_accum_a: assert property ((s_r.phase == jinc_pkg::PH_Q4) && isInc && !s_r.instr[7]
        |=> accum_r == $past(s_r.result)) else $error("accumulator not written");
    dest_file_a: assert property ((s_r.phase == jinc_pkg::PH_Q4) && isInc && s_r.instr[7]
        |-> memWe && memWAddr == fAddr ##1 $stable(accum_r)) else $error("file not written");
    inc_length_a: assert property (!busy_r && instrStart && instrWord[13:8] == 6'h0A
        |=> !done_r [*4] ##1 done_r) else $error("increment not one cycle");
    zero_flag_a: assert property ((s_r.phase == jinc_pkg::PH_Q4) && isInc && !s_r.secondCyc
        |=> zeroFlag_r == ($past(s_r.result) == 8'h00)) else $error("zero flag wrong");

    // Phases step in order, one per clock
    phase_q1_a: assert property (s_r.phase == jinc_pkg::PH_Q1
        |=> s_r.phase == jinc_pkg::PH_Q2) else $error("phase after Q1 wrong");

    // Read phase is always followed by the compute phase
    phase_q2_a: assert property (s_r.phase == jinc_pkg::PH_Q2
        |=> s_r.phase == jinc_pkg::PH_Q3) else $error("phase after Q2 wrong");

    // Compute phase is always followed by the write phase
    phase_q3_a: assert property (s_r.phase == jinc_pkg::PH_Q3
        |=> s_r.phase == jinc_pkg::PH_Q4) else $error("phase after Q3 wrong");

    // Bank is written only in the write phase while an instruction runs
    busy_write_a: assert property (busy_r && s_r.phase != jinc_pkg::PH_Q4
        |-> !memWe) else $error("bank written outside write phase");

    // A jump never writes the file bank
    jump_write_a: assert property (busy_r && isJump
        |-> !memWe) else $error("jump wrote the bank");

    // A jump leaves the accumulator alone for both cycles
    jump_accum_a: assert property (!busy_r && instrStart && instrWord[13:11] == 3'h5
        |=> $stable(accum_r) [*8]) else $error("jump changed accumulator");

    // An increment never moves the program counter
    inc_pc_a: assert property (!busy_r && instrStart && instrWord[13:8] == 6'h0A
        |=> $stable(pc_r) [*4]) else $error("increment moved pc");

    // Done is only ever raised once the sequencer is back at rest
    done_idle_a: assert property (done_r
        |-> !busy_r && s_r.phase == jinc_pkg::PH_IDLE) else $error("done while busy");

    // Done is a single-cycle pulse
    done_pulse_a: assert property (done_r
        |=> !done_r) else $error("done longer than one cycle");

    // A taken start always enters the decode phase
    busy_start_a: assert property (!busy_r && instrStart
        |=> busy_r && s_r.phase == jinc_pkg::PH_Q1) else $error("start not taken");

    // Busy holds until the last write phase of the instruction
    busy_hold_a: assert property (busy_r && !(s_r.phase == jinc_pkg::PH_Q4 &&
        (s_r.secondCyc || !isJump)) |=> busy_r) else $error("busy dropped early");

    // Zero flag moves only on an increment write phase
    zero_hold_a: assert property (!(s_r.phase == jinc_pkg::PH_Q4 && isInc)
        |=> $stable(zeroFlag_r)) else $error("zero flag moved");

    // Accumulator moves only on an increment aimed at it
    accum_hold_a: assert property (!(s_r.phase == jinc_pkg::PH_Q4 && isInc && !s_r.instr[7])
        |=> $stable(accum_r)) else $error("accumulator moved");

    // Program counter moves only in the first write phase of a jump
    pc_hold_a: assert property (!(s_r.phase == jinc_pkg::PH_Q4 && isJump && !s_r.secondCyc)
        |=> $stable(pc_r)) else $error("pc moved");

endmodule

`default_nettype wire

// ### tb/jump_and_increment_execute_bench.sv
`timescale 1ns/1ps
`default_nettype none

module jump_and_increment_execute_bench;
    logic        sysClk      = 1'b0;
    logic        rst         = 1'b1;
    logic        instrStart  = 1'b0;
    logic [13:0] instrWord   = 14'h0000;
    logic [4:0]  pcHighLatch = 5'h00;
    logic        extWe       = 1'b0;
    logic [6:0]  extAddr     = 7'h00;
    logic [7:0]  extData     = 8'h00;
    logic [12:0] pc;
    logic [7:0]  accum;
    logic        zeroFlag;
    logic        busy;
    logic        done;
    logic [7:0]  rdData;
    int          failures    = 0;
    int          checkCount  = 0;

    jinc_execute dut (.sys_clk(sysClk), .rst(rst), .instrStart(instrStart),
        .instrWord(instrWord), .pcHighLatch(pcHighLatch), .extWe(extWe),
        .extAddr(extAddr), .extData(extData), .pc_r(pc), .accum_r(accum),
        .zeroFlag_r(zeroFlag), .busy_r(busy), .done_r(done), .dbgRdData_r(rdData));

    // 10 MHz clock
    always #50 sysClk = ~sysClk;

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checkCount, failures);
        if (failures == 0 && checkCount > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [12:0] seen, input logic [12:0] exp, input string what);
        checkCount++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // Bank access only while idle; writes during execution would be dropped
    task automatic write_file(input logic [6:0] a, input logic [7:0] d);
        @(negedge sysClk);
        extWe = 1'b1;
        extAddr = a;
        extData = d;
        @(negedge sysClk);
        extWe = 1'b0;
    endtask

    task automatic read_file(input logic [6:0] a, output logic [7:0] d);
        @(negedge sysClk);
        extAddr = a;
        @(negedge sysClk);
        d = rdData;
    endtask

    // Returns the cycle after the start edge in which done was seen
    task automatic run_instr(input logic [13:0] word, output int k);
        @(negedge sysClk);
        instrStart = 1'b1;
        instrWord = word;
        @(negedge sysClk);
        instrStart = 1'b0;
        check(busy, 13'h0001, "busy set");
        k = 1;
        while (done !== 1'b1 && k < 20) begin
            @(negedge sysClk);
            k++;
        end
        if (k >= 20) begin
            failures++;
            $display("[ERR] %0t instruction never finished", $time);
        end else begin
            @(negedge sysClk);
            check(done, 13'h0000, "done pulse");
        end
    endtask

    task automatic inc_to_acc();
        int k;
        logic [7:0] d;
        write_file(7'h7F, 8'h41);
        run_instr({6'h0A, 1'b0, 7'h7F}, k);
        check(k, 13'h0005, "inc length");
        check(accum, 13'h0042, "acc result");
        check(zeroFlag, 13'h0000, "zero clear");
        read_file(7'h7F, d);
        check(d, 13'h0041, "file kept");
    endtask

    task automatic inc_wrap();
        int k;
        logic [7:0] d;
        write_file(7'h05, 8'hFF);
        run_instr({6'h0A, 1'b1, 7'h05}, k);
        check(k, 13'h0005, "inc length");
        check(zeroFlag, 13'h0001, "zero set");
        check(accum, 13'h0042, "acc kept");
        read_file(7'h05, d);
        check(d, 13'h0000, "wrap");
    endtask

    // Latch bit 2 is set in the first jump (0x0F) to catch a wrongly placed upper field
    task automatic jumps();
        int k;
        logic [4:0]  lat [2] = '{5'h0F, 5'h10};
        logic [10:0] imm [2] = '{11'h5A5, 11'h7FF};
        for (int i = 0; i < 2; i++) begin
            pcHighLatch = lat[i];
            run_instr({3'h5, imm[i]}, k);
            check(k, 13'h0009, "jump length");
            check(pc, {lat[i][4:3], imm[i]}, "jump target");
            check(zeroFlag, 13'h0001, "flag kept");
        end
    endtask

    initial begin
        repeat (10) @(negedge sysClk);
        rst = 1'b0;
        check(pc, 13'h0000, "pc reset");
        check(busy, 13'h0000, "busy reset");
        inc_to_acc();
        inc_wrap();
        jumps();
        // Zero flag is set here, so this run proves that it clears
        inc_to_acc();
        print_verdict();
    end
endmodule

`default_nettype wire
